// ### async_memory_strobe_sequencer.sv
`timescale 1ns/1ps
// Function
// - unit is one clock, or two at half rate
// - read lasts setup+strobe+hold, plus sixteen per wait
// - write lasts setup+strobe+hold, plus sixteen per wait
// - read strobe low for programmed strobe units
// - extended read strobe adds sixteen units per wait
// - read select brackets strobe, or follows strobe
// - write select brackets strobe, or follows strobe
// - read address held over setup and hold
// - read byte lanes held over setup and hold
// - write address held over setup and hold
// - write byte lanes held over setup and hold
// - read strobe rises four units after release
// - wait sampling referenced to nominal hold start
// - extended write strobe adds sixteen units per wait
// - wait bounded by programmable maximum, then timeout
// - setup, strobe, hold, turnaround and maximum wait counts programmable by software; wait unit, lead and release counts fixed
module async_memory_strobe_sequencer #(
  parameter int SETUP_W  = 4,
  parameter int STROBE_W = 6,
  parameter int HOLD_W   = 3,
  parameter int TURN_W   = 2
) (
  input  wire logic                                     MCLK,
  input  wire logic                                     RST,
  input  wire logic                                     HALF_RATE,
  input  wire logic                                     EXTENDED_WAIT_ENABLE,
  input  wire logic                                     SELECT_STROBE,
  input  wire logic [SETUP_W-1:0]                       READ_SETUP_UNITS,
  input  wire logic [STROBE_W-1:0]                      READ_STROBE_UNITS,
  input  wire logic [HOLD_W-1:0]                        READ_HOLD_UNITS,
  input  wire logic [SETUP_W-1:0]                       WRITE_SETUP_UNITS,
  input  wire logic [STROBE_W-1:0]                      WRITE_STROBE_UNITS,
  input  wire logic [HOLD_W-1:0]                        WRITE_HOLD_UNITS,
  input  wire logic [TURN_W-1:0]                        TURNAROUND_UNITS,
  input  wire logic [strobe_seq_pkg::CNT_W-1:0]         MAX_WAIT_TIMEOUT,
  input  wire logic                                     REQ_VALID,
  output logic                                          REQ_READY,
  input  wire logic                                     REQ_WRITE,
  input  wire logic [strobe_seq_pkg::REGION_W-1:0]      REQ_REGION,
  input  wire logic [strobe_seq_pkg::ADDR_W-1:0]        REQ_ADDR,
  input  wire logic [strobe_seq_pkg::LANE_W-1:0]        REQ_LANE,
  input  wire logic [strobe_seq_pkg::DATA_W-1:0]        REQ_WDATA,
  output logic                                          DONE,
  output logic                                          TIMEOUT,
  output logic [strobe_seq_pkg::DATA_W-1:0]             RD_DATA,
  output logic [strobe_seq_pkg::CNT_W-1:0]              EXTERNAL_WAIT_CYCLES,
  input  wire logic                                     EXTERNAL_WAIT_IN,
  output logic [strobe_seq_pkg::CS_NUM-1:0]             CHIP_SELECT_N,
  output logic                                          READ_STROBE_N,
  output logic                                          WRITE_STROBE_N,
  output logic [strobe_seq_pkg::ADDR_W-1:0]             EXT_ADDRESS,
  output logic [strobe_seq_pkg::LANE_W-1:0]             BYTE_LANE_ADDRESS,
  input  wire logic [strobe_seq_pkg::DATA_W-1:0]        EXT_DATA_BUS_IN,
  output logic [strobe_seq_pkg::DATA_W-1:0]             EXT_DATA_BUS_OUT,
  output logic                                          EXT_DATA_BUS_OE
);

  // phase count loader, zero programmed treated as one unit
  function automatic logic [strobe_seq_pkg::CNT_W-1:0] load_units(
    input logic [strobe_seq_pkg::CNT_W-1:0] v
  );
    logic [strobe_seq_pkg::CNT_W-1:0] r;
    r = strobe_seq_pkg::CNT_ZERO;
    if (v != strobe_seq_pkg::CNT_ZERO)
    begin
      r = v - strobe_seq_pkg::CNT_ONE;
    end
    return r;
  endfunction

  strobe_seq_pkg::seq_state_t              state_r;
  strobe_seq_pkg::seq_state_t              state_nxt;
  logic [strobe_seq_pkg::CNT_W-1:0]        cnt_r;
  logic [strobe_seq_pkg::CNT_W-1:0]        cnt_nxt;
  logic [strobe_seq_pkg::CNT_W-1:0]        ewc_r;
  logic [strobe_seq_pkg::CNT_W-1:0]        ewc_nxt;
  logic                                    half_phase_r;
  logic                                    write_r;
  logic [strobe_seq_pkg::REGION_W-1:0]     region_r;
  logic                                    timeout_nxt;
  logic                                    done_nxt;

  wire logic accept    = REQ_VALID && (state_r == strobe_seq_pkg::ST_IDLE);
  wire logic unit_tick = HALF_RATE ? half_phase_r : 1'b1;
  wire logic cnt_end   = unit_tick && (cnt_r == strobe_seq_pkg::CNT_ZERO);
  wire logic [strobe_seq_pkg::CNT_W-1:0] cnt_dec =
    (cnt_end || !unit_tick) ? cnt_r : cnt_r - strobe_seq_pkg::CNT_ONE;
  wire logic op_write  = accept ? REQ_WRITE : write_r;

  // timing fields of the access in progress
  wire logic [strobe_seq_pkg::CNT_W-1:0] setup_u  =
    op_write ? strobe_seq_pkg::CNT_W'(WRITE_SETUP_UNITS)
             : strobe_seq_pkg::CNT_W'(READ_SETUP_UNITS);
  wire logic [strobe_seq_pkg::CNT_W-1:0] strobe_u =
    op_write ? strobe_seq_pkg::CNT_W'(WRITE_STROBE_UNITS)
             : strobe_seq_pkg::CNT_W'(READ_STROBE_UNITS);
  wire logic [strobe_seq_pkg::CNT_W-1:0] hold_u   =
    op_write ? strobe_seq_pkg::CNT_W'(WRITE_HOLD_UNITS)
             : strobe_seq_pkg::CNT_W'(READ_HOLD_UNITS);
  wire logic [strobe_seq_pkg::CNT_W-1:0] turn_u   =
    strobe_seq_pkg::CNT_W'(TURNAROUND_UNITS);

  // wait is looked at only inside the last units before nominal hold start
  wire logic wait_window = (cnt_r <= strobe_seq_pkg::LEAD_CNT);
  wire logic wait_hit    = EXTENDED_WAIT_ENABLE && EXTERNAL_WAIT_IN && wait_window;
  wire logic ewc_limit   = (ewc_r + strobe_seq_pkg::CNT_ONE) >= MAX_WAIT_TIMEOUT;

  wire logic strobe_on_nxt = (state_nxt == strobe_seq_pkg::ST_STROBE) ||
                             (state_nxt == strobe_seq_pkg::ST_WAITX)  ||
                             (state_nxt == strobe_seq_pkg::ST_RELEASE);
  wire logic frame_on_nxt  = strobe_on_nxt ||
                             (state_nxt == strobe_seq_pkg::ST_SETUP) ||
                             (state_nxt == strobe_seq_pkg::ST_HOLD);
  wire logic sel_region    = SELECT_STROBE ? strobe_on_nxt : frame_on_nxt;
  wire logic [strobe_seq_pkg::REGION_W-1:0] region_nxt = accept ? REQ_REGION : region_r;
  wire logic [strobe_seq_pkg::CS_NUM-1:0] cs_onehot =
    strobe_seq_pkg::CS_NUM'(1) << region_nxt;
  wire logic strobe_leaving = strobe_on_nxt == 1'b0 &&
                              (state_r == strobe_seq_pkg::ST_STROBE  ||
                               state_r == strobe_seq_pkg::ST_WAITX   ||
                               state_r == strobe_seq_pkg::ST_RELEASE);

  assign REQ_READY = (state_r == strobe_seq_pkg::ST_IDLE);

  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_dec;
    ewc_nxt     = ewc_r;
    timeout_nxt = 1'b0;
    done_nxt    = 1'b0;
    case (state_r)
      strobe_seq_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          ewc_nxt = strobe_seq_pkg::CNT_ZERO;
          if (turn_u != strobe_seq_pkg::CNT_ZERO)
          begin
            state_nxt = strobe_seq_pkg::ST_TURN;
            cnt_nxt   = load_units(turn_u);
          end
          else
          begin
            state_nxt = strobe_seq_pkg::ST_SETUP;
            cnt_nxt   = load_units(setup_u);
          end
        end
      end
      strobe_seq_pkg::ST_TURN:
      begin
        if (cnt_end)
        begin
          state_nxt = strobe_seq_pkg::ST_SETUP;
          cnt_nxt   = load_units(setup_u);
        end
      end
      strobe_seq_pkg::ST_SETUP:
      begin
        if (cnt_end)
        begin
          state_nxt = strobe_seq_pkg::ST_STROBE;
          cnt_nxt   = load_units(strobe_u);
        end
      end
      strobe_seq_pkg::ST_STROBE:
      begin
        if (unit_tick && wait_hit)
        begin
          state_nxt = strobe_seq_pkg::ST_WAITX;
          cnt_nxt   = strobe_seq_pkg::EWC_RELOAD;
        end
        else if (cnt_end)
        begin
          state_nxt = strobe_seq_pkg::ST_HOLD;
          cnt_nxt   = load_units(hold_u);
        end
      end
      strobe_seq_pkg::ST_WAITX:
      begin
        if (unit_tick && !EXTERNAL_WAIT_IN)
        begin
          state_nxt = strobe_seq_pkg::ST_RELEASE;
          cnt_nxt   = strobe_seq_pkg::RELEASE_CNT;
        end
        else if (cnt_end)
        begin
          ewc_nxt = ewc_r + strobe_seq_pkg::CNT_ONE;
          if (ewc_limit)
          begin
            state_nxt   = strobe_seq_pkg::ST_HOLD;
            cnt_nxt     = load_units(hold_u);
            timeout_nxt = 1'b1;
          end
          else
          begin
            cnt_nxt = strobe_seq_pkg::EWC_RELOAD;
          end
        end
      end
      strobe_seq_pkg::ST_RELEASE:
      begin
        if (cnt_end)
        begin
          state_nxt = strobe_seq_pkg::ST_HOLD;
          cnt_nxt   = load_units(hold_u);
        end
      end
      strobe_seq_pkg::ST_HOLD:
      begin
        if (cnt_end)
        begin
          state_nxt = strobe_seq_pkg::ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      default:
      begin
        state_nxt = strobe_seq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state_r      <= strobe_seq_pkg::ST_IDLE;
      cnt_r        <= strobe_seq_pkg::CNT_ZERO;
      ewc_r        <= strobe_seq_pkg::CNT_ZERO;
      half_phase_r <= 1'b0;
      write_r      <= 1'b0;
      region_r     <= '0;
    end
    else
    begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      ewc_r        <= ewc_nxt;
      half_phase_r <= accept ? 1'b0 : ~half_phase_r;
      write_r      <= op_write;
      region_r     <= region_nxt;
    end
  end

  // registered pin drive
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      CHIP_SELECT_N        <= strobe_seq_pkg::CS_IDLE;
      READ_STROBE_N        <= 1'b1;
      WRITE_STROBE_N       <= 1'b1;
      EXT_ADDRESS          <= '0;
      BYTE_LANE_ADDRESS    <= '0;
      EXT_DATA_BUS_OUT     <= '0;
      EXT_DATA_BUS_OE      <= 1'b0;
      RD_DATA              <= '0;
      DONE                 <= 1'b0;
      TIMEOUT              <= 1'b0;
      EXTERNAL_WAIT_CYCLES <= strobe_seq_pkg::CNT_ZERO;
    end
    else
    begin
      CHIP_SELECT_N   <= sel_region ? ~cs_onehot : strobe_seq_pkg::CS_IDLE;
      READ_STROBE_N   <= ~(strobe_on_nxt && !op_write);
      WRITE_STROBE_N  <= ~(strobe_on_nxt && op_write);
      EXT_DATA_BUS_OE <= frame_on_nxt && op_write;
      DONE            <= done_nxt;
      TIMEOUT         <= timeout_nxt;
      if (accept)
      begin
        EXT_ADDRESS       <= REQ_ADDR;
        BYTE_LANE_ADDRESS <= REQ_LANE;
        EXT_DATA_BUS_OUT  <= REQ_WDATA;
      end
      if (strobe_leaving && !write_r)
      begin
        RD_DATA <= EXT_DATA_BUS_IN;
      end
      if (done_nxt)
      begin
        EXTERNAL_WAIT_CYCLES <= ewc_r;
      end
    end
  end

endmodule

// ### async_memory_strobe_sequencer_props.sv
`timescale 1ns/1ps
module strobe_seq_checker #(
  parameter int SETUP_W  = 4,
  parameter int STROBE_W = 6,
  parameter int HOLD_W   = 3
) (
  input wire logic                                 MCLK,
  input wire logic                                 RST,
  input wire logic                                 HALF_RATE,
  input wire logic                                 EXTENDED_WAIT_ENABLE,
  input wire logic                                 SELECT_STROBE,
  input wire logic [SETUP_W-1:0]                   READ_SETUP_UNITS,
  input wire logic [STROBE_W-1:0]                  READ_STROBE_UNITS,
  input wire logic [HOLD_W-1:0]                    READ_HOLD_UNITS,
  input wire logic [SETUP_W-1:0]                   WRITE_SETUP_UNITS,
  input wire logic [STROBE_W-1:0]                  WRITE_STROBE_UNITS,
  input wire logic [HOLD_W-1:0]                    WRITE_HOLD_UNITS,
  input wire logic                                 EXTERNAL_WAIT_IN,
  input wire logic [strobe_seq_pkg::CS_NUM-1:0]    CHIP_SELECT_N,
  input wire logic                                 READ_STROBE_N,
  input wire logic                                 WRITE_STROBE_N,
  input wire logic [strobe_seq_pkg::ADDR_W-1:0]    EXT_ADDRESS,
  input wire logic [strobe_seq_pkg::LANE_W-1:0]    BYTE_LANE_ADDRESS,
  input wire logic                                 TIMEOUT,
  input wire logic                                 DONE
);
  logic [7:0] cs_age_r;
  logic [7:0] str_low_r;
  logic [7:0] since_str_r;
  logic       last_wr_r;
  wire        str_hi  = READ_STROBE_N & WRITE_STROBE_N;
  wire        cs_idle = &CHIP_SELECT_N;
  function automatic logic [7:0] eff(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction
  always_ff @(posedge MCLK)
  begin
    cs_age_r    <= (RST || cs_idle) ? 8'h00 : cs_age_r + 8'h01;
    str_low_r   <= (RST || str_hi) ? 8'h00 : str_low_r + 8'h01;
    since_str_r <= (RST || !str_hi) ? 8'h00 : since_str_r + 8'h01;
    last_wr_r   <= !WRITE_STROBE_N ? 1'b1 : (!READ_STROBE_N ? 1'b0 : last_wr_r);
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_wait_off;
    $fell(EXTERNAL_WAIT_IN) && !READ_STROBE_N && EXTENDED_WAIT_ENABLE && !HALF_RATE;
  endsequence
  sequence s_rd_up;
    $rose(READ_STROBE_N);
  endsequence
  property p_one_cs;
    $countones(~CHIP_SELECT_N) <= 1;
  endproperty
  property p_setup;
    $fell(str_hi) && !SELECT_STROBE && !HALF_RATE |-> cs_age_r ==
      (WRITE_STROBE_N ? eff(8'(READ_SETUP_UNITS)) : eff(8'(WRITE_SETUP_UNITS)));
  endproperty
  property p_hold;
    $rose(cs_idle) && !SELECT_STROBE && !HALF_RATE |-> since_str_r ==
      (last_wr_r ? eff(8'(WRITE_HOLD_UNITS)) : eff(8'(READ_HOLD_UNITS)));
  endproperty
  property p_width;
    $rose(str_hi) && !EXTENDED_WAIT_ENABLE && !HALF_RATE |-> str_low_r ==
      (last_wr_r ? eff(8'(WRITE_STROBE_UNITS)) : eff(8'(READ_STROBE_UNITS)));
  endproperty
  property p_ss_rd;
    SELECT_STROBE && $fell(READ_STROBE_N) |-> $past(cs_idle) && !cs_idle;
  endproperty
  property p_ss_wr;
    SELECT_STROBE && $rose(WRITE_STROBE_N) |-> cs_idle;
  endproperty
  property p_addr;
    $changed(EXT_ADDRESS) |-> $past(cs_idle) && $past(str_hi);
  endproperty
  property p_lane;
    $changed(BYTE_LANE_ADDRESS) |-> $past(cs_idle) && $past(str_hi);
  endproperty
  property p_release;
    s_wait_off |-> ##[3:5] s_rd_up;
  endproperty
  property p_timeout;
    TIMEOUT |-> ##[1:40] DONE;
  endproperty
  a_one_cs: assert property (p_one_cs) else $error("two selects low");
  a_setup: assert property (p_setup) else $error("select setup wrong");
  a_hold: assert property (p_hold) else $error("select hold wrong");
  a_width: assert property (p_width) else $error("strobe width wrong");
  a_ss_rd: assert property (p_ss_rd) else $error("select not with read strobe");
  a_ss_wr: assert property (p_ss_wr) else $error("select not with write strobe");
  a_addr: assert property (p_addr) else $error("address moved in access");
  a_lane: assert property (p_lane) else $error("lane moved in access");
  a_release: assert property (p_release) else $error("strobe late after wait");
  a_timeout: assert property (p_timeout) else $error("no done after timeout");
endmodule
bind async_memory_strobe_sequencer strobe_seq_checker #(.SETUP_W(SETUP_W),
  .STROBE_W(STROBE_W), .HOLD_W(HOLD_W)) i_checker (
  .MCLK                 (MCLK),
  .RST                  (RST),
  .HALF_RATE            (HALF_RATE),
  .EXTENDED_WAIT_ENABLE (EXTENDED_WAIT_ENABLE),
  .SELECT_STROBE        (SELECT_STROBE),
  .READ_SETUP_UNITS     (READ_SETUP_UNITS),
  .READ_STROBE_UNITS    (READ_STROBE_UNITS),
  .READ_HOLD_UNITS      (READ_HOLD_UNITS),
  .WRITE_SETUP_UNITS    (WRITE_SETUP_UNITS),
  .WRITE_STROBE_UNITS   (WRITE_STROBE_UNITS),
  .WRITE_HOLD_UNITS     (WRITE_HOLD_UNITS),
  .EXTERNAL_WAIT_IN     (EXTERNAL_WAIT_IN),
  .CHIP_SELECT_N        (CHIP_SELECT_N),
  .READ_STROBE_N        (READ_STROBE_N),
  .WRITE_STROBE_N       (WRITE_STROBE_N),
  .EXT_ADDRESS          (EXT_ADDRESS),
  .BYTE_LANE_ADDRESS    (BYTE_LANE_ADDRESS),
  .TIMEOUT              (TIMEOUT),
  .DONE                 (DONE));

// ### async_memory_strobe_sequencer_tb.sv
`timescale 1ns/1ps
module async_memory_strobe_sequencer_tb;
  logic        mclk, rst, hr, ew, ss, req_valid, req_write, ready, done, tmo, rd_n, wr_n;
  logic        oe, wait_in, seen_tmo, oe_seen;
  logic [1:0]  ta, region, lane, lane_o;
  logic [2:0]  hu;
  logic [3:0]  su, cs_n, cs_acc;
  logic [5:0]  tu;
  logic [7:0]  max_wait, wait_clks, external_wait_cycles;
  logic [15:0] wdata, rdata, dout, din;
  logic [20:0] addr, addr_o;
  int          n_errors, total_checks, cyc, n;
  async_memory_strobe_sequencer i_dut (
    .MCLK(mclk), .RST(rst), .HALF_RATE(hr), .EXTENDED_WAIT_ENABLE(ew), .SELECT_STROBE(ss),
    .READ_SETUP_UNITS(su), .READ_STROBE_UNITS(tu), .READ_HOLD_UNITS(hu),
    .WRITE_SETUP_UNITS(su), .WRITE_STROBE_UNITS(tu), .WRITE_HOLD_UNITS(hu),
    .TURNAROUND_UNITS(ta), .MAX_WAIT_TIMEOUT(max_wait), .REQ_VALID(req_valid),
    .REQ_READY(ready), .REQ_WRITE(req_write), .REQ_REGION(region), .REQ_ADDR(addr),
    .REQ_LANE(lane), .REQ_WDATA(wdata), .DONE(done), .TIMEOUT(tmo), .RD_DATA(rdata),
    .EXTERNAL_WAIT_CYCLES(external_wait_cycles), .EXTERNAL_WAIT_IN(wait_in), .CHIP_SELECT_N(cs_n),
    .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .EXT_ADDRESS(addr_o),
    .BYTE_LANE_ADDRESS(lane_o), .EXT_DATA_BUS_IN(din), .EXT_DATA_BUS_OUT(dout),
    .EXT_DATA_BUS_OE(oe));
  mem_partner i_mem (.MCLK(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .wait_clks(wait_clks), .wait_out(wait_in), .data_out(din));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cfg(input logic h, e, s, input logic [1:0] a, input logic [3:0] sv,
                     input logic [5:0] tv, input logic [2:0] hv, input logic [7:0] w, m);
    @(posedge mclk);
    {hr, ew, ss, ta, su, tu, hu, wait_clks, max_wait} <= {h, e, s, a, sv, tv, hv, w, m};
  endtask
  task automatic access(input logic w, input logic [1:0] rg, input logic [20:0] a);
    n = 0;
    seen_tmo = 1'b0;
    oe_seen = 1'b0;
    cs_acc = 4'hF;
    @(posedge mclk);
    {req_valid, req_write, region, addr, lane, wdata} <= {1'b1, w, rg, a, a[1:0],
                                                          a[15:0] ^ 16'h3C5A};
    @(negedge mclk);
    while (ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    req_valid <= 1'b0;
    while (done !== 1'b1 && n < 2000)
    begin
      @(negedge mclk);
      n++;
      seen_tmo = seen_tmo | tmo;
      cs_acc = cs_acc & cs_n;
      oe_seen = oe_seen | oe;
    end
    chk("access done", 32'h1, done);
  endtask
  task automatic t_read;
    cfg(1'b0, 1'b0, 1'b0, 2'h0, 4'h2, 6'h03, 3'h1, 8'h00, 8'h08);
    access(1'b0, 2'h1, 21'h1ABCD);
    chk("read cycles", 32'h7, n);
    chk("read data", 32'hA5C3, rdata);
    chk("read address", 32'h1ABCD, addr_o);
    chk("read lane", 32'h1, lane_o);
    chk("read select", 32'hD, cs_acc);
    chk("read bus drive", 32'h0, oe_seen);
    $display("test read done");
  endtask
  task automatic t_write_half;
    cfg(1'b1, 1'b0, 1'b1, 2'h1, 4'h1, 6'h02, 3'h3, 8'h00, 8'h08);
    access(1'b1, 2'h2, 21'h0F00E);
    chk("write cycles", 32'hF, n);
    chk("write data", 32'hCC54, dout);
    chk("write lane", 32'h2, lane_o);
    chk("write select", 32'hB, cs_acc);
    chk("write address", 32'h0F00E, addr_o);
    chk("write bus drive", 32'h1, oe_seen);
    chk("write bus released", 32'h0, oe);
    $display("test write half rate done");
  endtask
  task automatic t_zero;
    cfg(1'b0, 1'b0, 1'b0, 2'h3, 4'h0, 6'h00, 3'h0, 8'h00, 8'h08);
    access(1'b1, 2'h3, 21'h00003);
    chk("zero count cycles", 32'h7, n);
    chk("zero count select", 32'h7, cs_acc);
    $display("test zero counts done");
  endtask
  task automatic t_release;
    cfg(1'b0, 1'b1, 1'b0, 2'h0, 4'h1, 6'h06, 3'h1, 8'h28, 8'h08);
    access(1'b0, 2'h0, 21'h00010);
    chk("wait cycles", 32'h2, external_wait_cycles);
    chk("no timeout", 32'h0, seen_tmo);
    $display("test wait release done");
  endtask
  task automatic t_wait_write;
    cfg(1'b0, 1'b1, 1'b0, 2'h0, 4'h1, 6'h06, 3'h1, 8'h28, 8'h08);
    access(1'b1, 2'h3, 21'h00030);
    chk("write wait cycles", 32'h2, external_wait_cycles);
    chk("write wait no timeout", 32'h0, seen_tmo);
    chk("write wait select", 32'h7, cs_acc);
    $display("test write wait done");
  endtask
  task automatic t_timeout;
    cfg(1'b0, 1'b1, 1'b1, 2'h0, 4'h1, 6'h06, 3'h2, 8'h78, 8'h02);
    access(1'b0, 2'h1, 21'h00020);
    chk("timeout seen", 32'h1, seen_tmo);
    chk("timeout wait cycles", 32'h2, external_wait_cycles);
    $display("test timeout done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim();
    end
  end
  initial
  begin
    {hr, ew, ss, ta, su, tu, hu, wait_clks, max_wait} = '0;
    {req_valid, req_write, region, addr, lane, wdata} = '0;
    {n_errors, total_checks, cyc} = '0;
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_read();
    t_write_half();
    t_zero();
    t_release();
    t_wait_write();
    t_timeout();
    end_sim();
  end
endmodule

// ### mem_partner.sv
`timescale 1ns/1ps
module mem_partner (
  input  wire logic        MCLK,
  input  wire logic [3:0]  cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [7:0]  wait_clks,
  output logic             wait_out,
  output logic [15:0]      data_out
);
  int   left;
  logic hi_d;
  wire  start = hi_d && !(rd_n && wr_n) && (wait_clks != 8'h00);
  initial
  begin
    left = 0;
    hi_d = 1'b1;
    wait_out = 1'b0;
    data_out = 16'h0000;
  end
  always @(posedge MCLK)
  begin
    hi_d <= rd_n & wr_n;
    left <= start ? int'(wait_clks) : ((left > 0) ? left - 1 : 0);
    wait_out <= start || (left > 1);
    data_out <= (!rd_n && !(&cs_n)) ? 16'hA5C3 : ~data_out;
  end
endmodule

// ### strobe_seq_pkg.sv
package strobe_seq_pkg;
  localparam int CNT_W           = 8;
  localparam int ADDR_W          = 21;
  localparam int LANE_W          = 2;
  localparam int DATA_W          = 16;
  localparam int CS_NUM          = 4;
  localparam int REGION_W        = 2;
  localparam int UNITS_PER_EWC   = 16;
  localparam int WAIT_LEAD_UNITS = 4;
  localparam int RELEASE_UNITS   = 4;
  localparam logic [CNT_W-1:0] EWC_RELOAD   = 8'(UNITS_PER_EWC - 1);
  localparam logic [CNT_W-1:0] LEAD_CNT     = 8'(WAIT_LEAD_UNITS - 1);
  localparam logic [CNT_W-1:0] RELEASE_CNT  = 8'(RELEASE_UNITS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO     = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE      = 8'h01;
  localparam logic [CS_NUM-1:0] CS_IDLE     = 4'hF;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'b0000001,
    ST_TURN    = 7'b0000010,
    ST_SETUP   = 7'b0000100,
    ST_STROBE  = 7'b0001000,
    ST_WAITX   = 7'b0010000,
    ST_RELEASE = 7'b0100000,
    ST_HOLD    = 7'b1000000
  } seq_state_t;
endpackage
